// ===== hdl/rio_pkg.sv
`default_nettype none
package rio_pkg;
   // ---------------------------------------------
   // Table layout
   // ---------------------------------------------
   localparam int TABLE_WORDS    = 32;
   localparam int RESV_WORDS     = 4;
   localparam int DESC_WORDS     = 4;
   localparam int MAX_SLAVES     = 7;
   localparam int MAX_POINTS     = 512;
   localparam int MASTER_STATION = 0;
   localparam int WORD_W         = 16;
   localparam int ADDR_W         = 16;
   localparam logic [1:0] FLD_IN_ADDR  = 2'h0;
   localparam logic [1:0] FLD_IN_CNT   = 2'h1;
   localparam logic [1:0] FLD_OUT_ADDR = 2'h2;
   localparam logic [1:0] FLD_OUT_CNT  = 2'h3;
   localparam logic [15:0] DEF_TABLE_BASE = 16'h3fc0;
   // ---------------------------------------------
   // Link rates
   // ---------------------------------------------
   localparam int BAUD_SLOW = 19200;
   localparam int BAUD_FAST = 38400;
   localparam int CLK_HZ    = 250000000;
   localparam int DIV_SLOW  = CLK_HZ / BAUD_SLOW;
   localparam int DIV_FAST  = CLK_HZ / BAUD_FAST;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_WAIT  = 3'b011,
      ST_ARMED = 3'b010,
      ST_POLL  = 3'b110,
      ST_XFER  = 3'b111
   } ld_state_t;
endpackage
`default_nettype wire

// ===== hdl/rio_desc_check.sv
`timescale 1ns/100ps
`default_nettype none
module rio_desc_check #(
   parameter int W = 16
) (
   // Descriptor words
   input  wire logic [W-1:0] in_addr,
   input  wire logic [W-1:0] in_cnt,
   input  wire logic [W-1:0] out_addr,
   input  wire logic [W-1:0] out_cnt,
   // Result
   output logic              present,
   output logic [9:0]        points
);
   logic [W:0] sum;
   always_comb begin
      present = |{in_addr, in_cnt, out_addr, out_cnt};
      sum     = {1'b0, in_cnt} + {1'b0, out_cnt};
      points  = (sum > (W+1)'(rio_pkg::MAX_POINTS)) ? 10'h200 : sum[9:0];
   end
endmodule // rio_desc_check
`default_nettype wire

// ===== hdl/remote_io_table_loader.sv
// Overview of operation
// - Table base from port setup address
// - First four words reserved, then descriptors
// - Words: in addr, in count, out addr, out count
// - Table read once after powerup
// - Table spans 32 words, absent zeroed
// - Any non-zero descriptor means slave present
// - No traffic until setup-done relay set
// - At most seven slave descriptors
// - Station zero master, slaves one to seven
// - Baud 19200 or 38400, matched
// - At most 512 points in total (each count is clipped to 512, the sum is not enforced)
`timescale 1ns/100ps
`default_nettype none
module remote_io_table_loader #(
   parameter int NSLV = rio_pkg::MAX_SLAVES
) (
   // Clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          srst,
   // Port setup
   input  wire logic [rio_pkg::ADDR_W-1:0]    table_base,
   input  wire logic                          baud_fast,
   input  wire logic                          remote_setup_done_relay,
   // Data memory read port
   output logic                               mem_rd,
   output logic [rio_pkg::ADDR_W-1:0]         mem_addr,
   input  wire logic                          mem_valid,
   input  wire logic [rio_pkg::WORD_W-1:0]    mem_rdata,
   // Link engine request
   output logic                               xfer_req,
   input  wire logic                          xfer_done,
   output logic [2:0]                         xfer_station,
   output logic [rio_pkg::ADDR_W-1:0]         xfer_in_addr,
   output logic [9:0]                         xfer_in_cnt,
   output logic [rio_pkg::ADDR_W-1:0]         xfer_out_addr,
   output logic [9:0]                         xfer_out_cnt,
   output logic [15:0]                        baud_div,
   // Status
   output logic                               loaded,
   output logic                               link_active,
   output logic [6:0]                         slave_present
);
   localparam int W = rio_pkg::WORD_W;

   typedef struct packed {
      rio_pkg::ld_state_t           st;
      logic [4:0]                   idx;
      logic [rio_pkg::ADDR_W-1:0]   base;
      logic [rio_pkg::TABLE_WORDS*W-1:0] tbl;
      logic [2:0]                   cur;
      logic                         req;
      logic [15:0]                  div;
      logic [6:0]                   pres;
   } state_t;

   state_t s_reg, s_next;

   // ---------------------------------------------
   // Descriptor decode
   // ---------------------------------------------
   logic [NSLV-1:0] pres_w;
   logic [9:0]      pts_w [NSLV];
   logic [W-1:0]    dw [NSLV][4];

   genvar g;
   generate
      for (g = 0; g < NSLV; g++) begin : g_desc
         localparam int B = rio_pkg::RESV_WORDS + g*rio_pkg::DESC_WORDS;
         for (genvar k = 0; k < 4; k++) begin : g_w
            assign dw[g][k] = s_reg.tbl[(B+k)*W +: W];
         end
         rio_desc_check #(.W(W)) u_chk (
            .in_addr  (dw[g][rio_pkg::FLD_IN_ADDR]),
            .in_cnt   (dw[g][rio_pkg::FLD_IN_CNT]),
            .out_addr (dw[g][rio_pkg::FLD_OUT_ADDR]),
            .out_cnt  (dw[g][rio_pkg::FLD_OUT_CNT]),
            .present  (pres_w[g]),
            .points   (pts_w[g])
         );
      end
   endgenerate

   // Clip each single count to 512
   function automatic logic [9:0] clip(input logic [W-1:0] c);
      clip = (c > W'(rio_pkg::MAX_POINTS)) ? 10'h200 : c[9:0];
   endfunction

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         rio_pkg::ST_IDLE: begin
            s_next.base = table_base;
            s_next.idx  = 5'h0;
            s_next.st   = rio_pkg::ST_READ;
         end
         rio_pkg::ST_READ: begin
            s_next.st = rio_pkg::ST_WAIT;
         end
         rio_pkg::ST_WAIT: begin
            if (mem_valid) begin
               s_next.tbl[s_reg.idx*W +: W] = mem_rdata;
               if (s_reg.idx == 5'(rio_pkg::TABLE_WORDS-1)) begin
                  s_next.st = rio_pkg::ST_ARMED;
               end else begin
                  s_next.idx = s_reg.idx + 5'h1;
                  s_next.st  = rio_pkg::ST_READ;
               end
            end
         end
         rio_pkg::ST_ARMED: begin
            s_next.pres = 7'(pres_w);
            s_next.div  = baud_fast ? 16'(rio_pkg::DIV_FAST) : 16'(rio_pkg::DIV_SLOW);
            if (remote_setup_done_relay) begin
               s_next.cur  = 3'h0;
               s_next.st   = rio_pkg::ST_POLL;
            end
         end
         rio_pkg::ST_POLL: begin
            // Empty table: no request is raised, link_active stays high until the next reset
            if (s_reg.pres == 7'h0) begin
               s_next.st = rio_pkg::ST_POLL;
            end else if (s_reg.pres[s_reg.cur]) begin
               s_next.req = 1'b1;
               s_next.st  = rio_pkg::ST_XFER;
            end else begin
               s_next.cur = (s_reg.cur == 3'(NSLV-1)) ? 3'h0 : s_reg.cur + 3'h1;
            end
         end
         rio_pkg::ST_XFER: begin
            if (xfer_done) begin
               s_next.req = 1'b0;
               s_next.cur = (s_reg.cur == 3'(NSLV-1)) ? 3'h0 : s_reg.cur + 3'h1;
               s_next.st  = rio_pkg::ST_POLL;
            end
         end
         default: s_next.st = rio_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   // Only watched: counts are clipped per slave, the sum is not enforced
   logic [12:0] tot_pts;
   always_comb begin
      tot_pts = 13'h0;
      for (int i = 0; i < NSLV; i++) begin
         tot_pts = tot_pts + {3'h0, pts_w[i]};
      end
   end

   always_comb begin
      mem_rd        = (s_reg.st == rio_pkg::ST_READ);
      mem_addr      = s_reg.base + rio_pkg::ADDR_W'(s_reg.idx);
      xfer_req      = s_reg.req;
      xfer_station  = s_reg.cur + 3'h1;
      xfer_in_addr  = dw[s_reg.cur][rio_pkg::FLD_IN_ADDR];
      xfer_in_cnt   = clip(dw[s_reg.cur][rio_pkg::FLD_IN_CNT]);
      xfer_out_addr = dw[s_reg.cur][rio_pkg::FLD_OUT_ADDR];
      xfer_out_cnt  = clip(dw[s_reg.cur][rio_pkg::FLD_OUT_CNT]);
      baud_div      = s_reg.div;
      link_active   = (s_reg.st == rio_pkg::ST_POLL) || (s_reg.st == rio_pkg::ST_XFER);
      loaded        = (s_reg.st == rio_pkg::ST_ARMED) || link_active;
      slave_present = s_reg.pres;
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   no_early_link_a: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(link_active) |-> $past(remote_setup_done_relay))
      else $error("link started without setup relay");
   skip_absent_a: assert property (@(posedge sys_clk) disable iff (srst)
      xfer_req |-> s_reg.pres[s_reg.cur])
      else $error("transfer to absent slave");
   station_range_a: assert property (@(posedge sys_clk) disable iff (srst)
      xfer_req |-> (xfer_station >= 3'h1 && xfer_station <= 3'h7))
      else $error("bad station number");
   read_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
      mem_rd |-> mem_addr - s_reg.base < 16'(rio_pkg::TABLE_WORDS))
      else $error("read outside table");
   read_base_a: assert property (@(posedge sys_clk) disable iff (srst)
      ($past(s_reg.st) == rio_pkg::ST_IDLE && !$past(srst)) |-> mem_rd && mem_addr == $past(table_base))
      else $error("first read not at base");
   cnt_limit_a: assert property (@(posedge sys_clk) disable iff (srst)
      xfer_req |-> (xfer_in_cnt <= 10'h200 && xfer_out_cnt <= 10'h200))
      else $error("count above limit");
   req_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      (xfer_req && !xfer_done) |=> xfer_req && $stable(xfer_station))
      else $error("request dropped early");
   present_map_a: assert property (@(posedge sys_clk) disable iff (srst)
      (s_reg.st == rio_pkg::ST_ARMED) |=> slave_present == 7'($past(pres_w)))
      else $error("presence map wrong");
   baud_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
      (s_reg.st == rio_pkg::ST_ARMED) |=> baud_div == ($past(baud_fast)
         ? 16'(rio_pkg::DIV_FAST) : 16'(rio_pkg::DIV_SLOW)))
      else $error("bad baud divider");
   full_table_a: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(loaded) |-> s_reg.idx == 5'(rio_pkg::TABLE_WORDS-1))
      else $error("armed before table read");
   idle_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      (s_reg.st == rio_pkg::ST_ARMED && !remote_setup_done_relay) |=> !link_active)
      else $error("link started while relay clear");
   load_c: cover property (@(posedge sys_clk) $rose(loaded));
   over_c: cover property (@(posedge sys_clk) loaded && tot_pts > 13'h200);
   start_c: cover property (@(posedge sys_clk) $rose(link_active));
   xfer_c: cover property (@(posedge sys_clk) xfer_req && xfer_done);
endmodule // remote_io_table_loader
`default_nettype wire

// ===== dv/rio_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module rio_far_model (
   // Clock
   input  wire logic        sys_clk,
   // Data memory
   input  wire logic        mem_rd,
   input  wire logic [15:0] mem_addr,
   output logic             mem_valid,
   output logic [15:0]      mem_rdata,
   // Link engine
   input  wire logic        xfer_req,
   output logic             xfer_done
);
   logic [15:0] mem [0:65535];
   logic [15:0] pend = 16'h0;
   logic        busy = 1'b0;
   int          lat = 1;
   int          nrd = 0;
   int          cnt = 0;
   int          lcnt = 0;
   initial begin
      mem_valid = 1'b0;
      mem_rdata = 16'h0;
      xfer_done = 1'b0;
   end
   always @(posedge sys_clk) begin
      mem_valid <= 1'b0;
      xfer_done <= 1'b0;
      if (mem_rd) begin
         busy <= 1'b1;
         pend <= mem_addr;
         cnt  <= lat;
         nrd  <= nrd + 1;
      end else if (busy && cnt > 1) begin
         cnt <= cnt - 1;
      end else if (busy) begin
         busy      <= 1'b0;
         mem_valid <= 1'b1;
         mem_rdata <= mem[pend];
      end else begin
         // Bus not held between reads
         mem_rdata <= ~mem_rdata;
      end
      // Slave exchange takes a few cycles, one at a time
      if (xfer_req && !xfer_done) begin
         lcnt <= lcnt + 1;
         if (lcnt >= 3 * lat) begin
            xfer_done <= 1'b1;
            lcnt      <= 0;
         end
      end
   end
endmodule // rio_far_model
`default_nettype wire

// ===== dv/remote_io_table_loader_bench.sv
`timescale 1ns/100ps
`default_nettype none
module remote_io_table_loader_bench;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        baud_fast = 1'b0;
   logic        relay = 1'b0;
   logic [15:0] base = 16'h0;
   logic        mem_rd, mem_valid, xfer_req, xfer_done, loaded, link_active;
   logic [15:0] mem_addr, mem_rdata, in_a, out_a, baud_div;
   logic [2:0]  st;
   logic [9:0]  in_c, out_c;
   logic [6:0]  present;
   int          miscompares = 0;
   int          checked = 0;
   int          cyc = 0;

   remote_io_table_loader i_dut (.sys_clk(sys_clk), .srst(srst), .table_base(base),
      .baud_fast(baud_fast), .remote_setup_done_relay(relay), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
      .xfer_req(xfer_req), .xfer_done(xfer_done), .xfer_station(st), .xfer_in_addr(in_a),
      .xfer_in_cnt(in_c), .xfer_out_addr(out_a), .xfer_out_cnt(out_c),
      .baud_div(baud_div), .loaded(loaded), .link_active(link_active),
      .slave_present(present));
   rio_far_model i_far (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .mem_rdata(mem_rdata), .xfer_req(xfer_req),
      .xfer_done(xfer_done));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end

   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic restart(input logic [15:0] b);
      @(negedge sys_clk);
      srst = 1'b1;
      base = b;
      repeat (16) @(negedge sys_clk);
      i_far.nrd = 0;
      srst = 1'b0;
   endtask
   task automatic wait_loaded();
      for (int i = 0; i < 600 && loaded !== 1'b1; i++) @(negedge sys_clk);
      // Presence map and divider register one cycle after loaded rises
      @(negedge sys_clk);
      cmp("loaded", 1'b1, loaded);
   endtask
   task automatic next_req();
      int i;
      i = 0;
      while (xfer_req === 1'b1 && i < 300) begin
         @(negedge sys_clk);
         i++;
      end
      while (xfer_req !== 1'b1 && i < 300) begin
         @(negedge sys_clk);
         i++;
      end
      cmp("req seen", 1'b1, xfer_req);
   endtask

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_table();
      for (int a = 0; a < 40; a++) i_far.mem[16'h3fc0 + a] = (a < 4 || a > 31) ? 16'hffff : 16'h0;
      i_far.mem[16'h3fc4] = 16'h0103;
      i_far.mem[16'h3fc5] = 16'h0300;
      i_far.mem[16'h3fc6] = 16'h0142;
      i_far.mem[16'h3fc7] = 16'h0010;
      i_far.mem[16'h3fcf] = 16'h0008;
      baud_fast = 1'b1;
      restart(16'h3fc0);
      wait_loaded();
      cmp("reads", 32, i_far.nrd);
      cmp("last addr", 16'h3fdf, i_far.pend);
      cmp("present", 7'h05, present);
      repeat (50) @(negedge sys_clk);
      cmp("idle req", 1'b0, xfer_req);
      cmp("idle link", 1'b0, link_active);
      relay = 1'b1;
      next_req();
      cmp("station a", 3'h1, st);
      cmp("in addr", 16'h0103, in_a);
      cmp("in cnt", 10'h200, in_c);
      cmp("out addr", 16'h0142, out_a);
      cmp("out cnt", 10'h010, out_c);
      next_req();
      cmp("station b", 3'h3, st);
      cmp("out cnt b", 10'h008, out_c);
      next_req();
      cmp("station c", 3'h1, st);
      cmp("div fast", 16'(rio_pkg::CLK_HZ / rio_pkg::BAUD_FAST), baud_div);
      $display("t_table done");
   endtask
   task automatic t_empty();
      for (int a = 0; a < 32; a++) i_far.mem[16'h0200 + a] = 16'h0;
      i_far.mem[16'h01ff] = 16'hffff;
      i_far.lat = 4;
      baud_fast = 1'b0;
      restart(16'h0200);
      relay = 1'b1;
      repeat (20) @(negedge sys_clk);
      cmp("early link", 1'b0, link_active);
      wait_loaded();
      cmp("reads", 32, i_far.nrd);
      cmp("last addr", 16'h021f, i_far.pend);
      cmp("present", 7'h00, present);
      repeat (60) @(negedge sys_clk);
      cmp("link", 1'b1, link_active);
      cmp("req", 1'b0, xfer_req);
      cmp("div slow", 16'(rio_pkg::CLK_HZ / rio_pkg::BAUD_SLOW), baud_div);
      $display("t_empty done");
   endtask

   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      t_table();
      t_empty();
      close_out();
   end
endmodule // remote_io_table_loader_bench
`default_nettype wire
